// ===== common/pdm_pkg.sv
// Constants shared by the power-down mode controller and its bench.
// Assumes a single 200 MHz APB clock domain.
package pdm_pkg;
    localparam int CLK_MHZ = 200;
    localparam logic [5:0] CODE_NONE = 6'h00;
    localparam logic [5:0] CODE_LIGHT_EN = 6'h09;
    localparam logic [5:0] CODE_LIGHT_ANY = 6'h11;
    localparam logic [5:0] CODE_CLK_HALT = 6'h1a;
    localparam logic [5:0] CODE_PLL_STOP = 6'h1c;
    localparam int FIELD_LSB = 10;
    localparam int FIELD_MSB = 15;
    localparam logic [3:0] ENTRY_DELAY = 4'h9;
    localparam int LOCK_TIME_US = 75;
    localparam int LOCK_CYCLES = LOCK_TIME_US * CLK_MHZ;
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_IRQEN = 12'h008;
    localparam logic [11:0] ADDR_EMUCFG = 12'h00c;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [15:0] IRQEN_RESET = 16'h0000;
    typedef enum logic [4:0] {
        ST_RUN = 5'b00001,
        ST_ARM = 5'b00010,
        ST_LIGHT = 5'b00100,
        ST_DEEP = 5'b01000,
        ST_LOCK = 5'b10000
    } pd_state_t;
endpackage

// ===== hw/sync2.sv
// Two-flop level synchroniser for a pin entering the pclk domain.
// Assumes the input is a slowly changing level.
`timescale 1ns/1ps
module sync2 (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic din,
    output logic dout
);
    logic meta_reg;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= 1'b0;
            dout <= 1'b0;
        end else begin
            meta_reg <= din;
            dout <= meta_reg;
        end
    end
endmodule // sync2

// ===== hw/emul_cfg_latch.sv
// Catches the emulation configuration pins on the test reset rising edge.
// Assumes inputs already synchronised to pclk.
`timescale 1ns/1ps
module emul_cfg_latch (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic test_rst_n_s,
    input wire logic cfg_hi_s,
    input wire logic cfg_lo_s,
    output logic [1:0] cfg_mode,
    output logic cfg_valid
);
    logic trst_d_reg;
    wire trst_rise = test_rst_n_s && !trst_d_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trst_d_reg <= 1'b0;
            cfg_mode <= 2'h0;
            cfg_valid <= 1'b0;
        end else begin
            trst_d_reg <= test_rst_n_s;
            if (trst_rise) begin
                cfg_mode <= {cfg_hi_s, cfg_lo_s};
                cfg_valid <= 1'b1;
            end else if (!test_rst_n_s) begin
                cfg_valid <= 1'b0;
            end
        end
    end
endmodule // emul_cfg_latch

// ===== hw/power_down_mode_control.sv
// Power-down mode controller with an APB register slave.
// Assumes pins are asynchronous and the CPU obeys halt and resume outputs.
//
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
module power_down_mode_control
    import pdm_pkg::*;
#(
    parameter int LOCK_WAIT = LOCK_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [15:0] irq_pending,
    input wire logic emu_attached,
    input wire logic emu_run_cmd,
    input wire logic test_rst_n,
    input wire logic emul_config_pin_hi,
    input wire logic emul_config_pin_lo,
    input wire logic pll_locked,
    output logic cpu_clk_gate,
    output logic cpu_halt,
    output logic irq_service,
    output logic resume,
    output logic transfer_controller_en,
    output logic clock_tree_halt,
    output logic pll_ref_stop,
    output logic io_freeze,
    output logic emu_spin_idle,
    output logic idcode_variant_valid,
    output logic [1:0] emul_mode
);
    logic emu_s, run_s, trst_s, hi_s, lo_s, lock_s;
    logic [31:0] ctrl_reg, ctrl_next;
    logic [15:0] irqen_reg;
    logic [3:0] delay_reg, delay_next;
    logic [31:0] lock_cnt_reg, lock_cnt_next;
    logic after_stop_reg;
    logic cfg_valid;
    logic [1:0] cfg_mode;
    pd_state_t state_reg, state_next;

    sync2 u_sync_emu (.clk(pclk), .rst_n(presetn), .din(emu_attached), .dout(emu_s));
    sync2 u_sync_run (.clk(pclk), .rst_n(presetn), .din(emu_run_cmd), .dout(run_s));
    sync2 u_sync_trst (.clk(pclk), .rst_n(presetn), .din(test_rst_n), .dout(trst_s));
    sync2 u_sync_hi (.clk(pclk), .rst_n(presetn), .din(emul_config_pin_hi), .dout(hi_s));
    sync2 u_sync_lo (.clk(pclk), .rst_n(presetn), .din(emul_config_pin_lo), .dout(lo_s));
    sync2 u_sync_lock (.clk(pclk), .rst_n(presetn), .din(pll_locked), .dout(lock_s));

    emul_cfg_latch u_cfg (
        .pclk(pclk),
        .presetn(presetn),
        .test_rst_n_s(trst_s),
        .cfg_hi_s(hi_s),
        .cfg_lo_s(lo_s),
        .cfg_mode(cfg_mode),
        .cfg_valid(cfg_valid)
    );

    // Global enable is bit 0 of the control word, the NMI enable bit 1 of the irq enable word.
    wire [5:0] sleep_select_field = ctrl_reg[FIELD_MSB:FIELD_LSB];
    wire global_irq_enable = ctrl_reg[0];
    wire nmi_enable_bit = irqen_reg[1];
    wire is_light = (sleep_select_field == CODE_LIGHT_EN) || (sleep_select_field == CODE_LIGHT_ANY);
    wire is_deep = (sleep_select_field == CODE_CLK_HALT) || (sleep_select_field == CODE_PLL_STOP);
    wire any_mode = (is_light || is_deep) && !emu_s;
    wire light_sleep = (state_reg == ST_LIGHT);
    wire any_irq = |irq_pending;
    wire en_irq = |(irq_pending & irqen_reg);
    wire wake_any = (sleep_select_field == CODE_LIGHT_ANY) && any_irq;
    wire wake = en_irq || wake_any;
    wire do_isr = en_irq && global_irq_enable && nmi_enable_bit;

    wire apb_setup = psel && !penable;
    wire apb_acc = psel && penable;
    wire wr_ctrl = apb_acc && pwrite && (paddr == ADDR_CTRL);
    wire wr_irqen = apb_acc && pwrite && (paddr == ADDR_IRQEN);
    wire addr_ok = (paddr == ADDR_CTRL) || (paddr == ADDR_STATUS) || (paddr == ADDR_IRQEN) ||
                   (paddr == ADDR_EMUCFG);
    wire [31:0] status_word = {27'h0, state_reg};
    wire [31:0] rd_mux = (paddr == ADDR_CTRL) ? ctrl_reg :
                         (paddr == ADDR_STATUS) ? status_word :
                         (paddr == ADDR_IRQEN) ? {16'h0, irqen_reg} :
                         (paddr == ADDR_EMUCFG) ? {29'h0, cfg_valid, cfg_mode} : 32'h0;

    always_comb begin
        state_next = state_reg;
        ctrl_next = ctrl_reg;
        delay_next = delay_reg;
        lock_cnt_next = lock_cnt_reg;
        if (wr_ctrl) begin
            ctrl_next = pwdata;
        end
        unique case (state_reg)
            ST_RUN: begin
                if (any_mode) begin
                    state_next = ST_ARM;
                    delay_next = ENTRY_DELAY;
                end
            end
            ST_ARM: begin
                if (!any_mode) begin
                    state_next = ST_RUN;
                end else if (delay_reg <= 4'h1) begin
                    state_next = is_deep ? ST_DEEP : ST_LIGHT;
                end else begin
                    delay_next = delay_reg - 4'h1;
                end
            end
            ST_LIGHT: begin
                if (wake || !any_mode) begin
                    state_next = ST_RUN;
                    ctrl_next[FIELD_MSB:FIELD_LSB] = CODE_NONE;
                end
            end
            ST_DEEP: begin
                state_next = ST_DEEP;
            end
            ST_LOCK: begin
                if (lock_s && lock_cnt_reg >= LOCK_WAIT - 1) begin
                    state_next = ST_RUN;
                end else begin
                    lock_cnt_next = lock_cnt_reg + 32'h1;
                end
            end
        endcase
        if (state_reg == ST_DEEP) begin
            ctrl_next = ctrl_reg;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_LOCK;
            ctrl_reg <= CTRL_RESET;
            irqen_reg <= IRQEN_RESET;
            delay_reg <= 4'h0;
            lock_cnt_reg <= 32'h0;
        end else begin
            state_reg <= state_next;
            ctrl_reg <= ctrl_next;
            delay_reg <= delay_next;
            lock_cnt_reg <= lock_cnt_next;
            if (wr_irqen) begin
                irqen_reg <= pwdata[15:0];
            end
        end
    end

    // Only reset passes the lock wait (ST_LOCK); a prior PLL-input stop sets after_stop_reg, which nothing reads, so it does not stretch it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            after_stop_reg <= 1'b0;
        end else if (state_reg == ST_DEEP && sleep_select_field == CODE_PLL_STOP) begin
            after_stop_reg <= 1'b1;
        end else if (state_reg == ST_RUN) begin
            after_stop_reg <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
            cpu_clk_gate <= 1'b0;
            cpu_halt <= 1'b1;
            irq_service <= 1'b0;
            resume <= 1'b0;
            transfer_controller_en <= 1'b0;
            clock_tree_halt <= 1'b0;
            pll_ref_stop <= 1'b0;
            io_freeze <= 1'b0;
            emu_spin_idle <= 1'b0;
            idcode_variant_valid <= 1'b0;
            emul_mode <= 2'h0;
        end else begin
            pready <= apb_setup;
            pslverr <= apb_setup && !addr_ok;
            prdata <= (apb_setup && !pwrite) ? rd_mux : 32'h0;
            cpu_clk_gate <= (state_next == ST_LIGHT) || (state_next == ST_DEEP);
            cpu_halt <= (state_next != ST_RUN) && (state_next != ST_ARM);
            irq_service <= light_sleep && wake && do_isr;
            resume <= light_sleep && (wake || !any_mode);
            transfer_controller_en <= (state_next != ST_DEEP) && (state_next != ST_LOCK);
            clock_tree_halt <= (state_next == ST_DEEP);
            pll_ref_stop <= (state_next == ST_DEEP) && (sleep_select_field == CODE_PLL_STOP);
            io_freeze <= (state_next == ST_DEEP);
            emu_spin_idle <= (state_next == ST_DEEP) && run_s;
            idcode_variant_valid <= 1'b1;
            emul_mode <= cfg_mode;
        end
    end
endmodule // power_down_mode_control

// ===== verification/pdm_asserts.sv
// Port checker for the power-down mode controller.
// Assumes one pclk domain and presetn as the only reset.
`timescale 1ns/1ps
module pdm_asserts (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic emu_attached,
    input wire logic cpu_clk_gate,
    input wire logic cpu_halt,
    input wire logic irq_service,
    input wire logic resume,
    input wire logic transfer_controller_en,
    input wire logic clock_tree_halt,
    input wire logic pll_ref_stop,
    input wire logic io_freeze,
    input wire logic emu_spin_idle
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // The emulator pin is synchronised inside, so the bench keeps it quiet around deep writes.
    wire deep_wr = psel && penable && pready && pwrite && paddr == 12'h000 && pwdata[15:10] == 6'h1a;
    deep_entry_a: assert property (deep_wr && !emu_attached && !cpu_halt |-> ##[1:12] clock_tree_halt)
        else $error("deep sleep not entered in time");
    deep_hold_a: assert property (clock_tree_halt |=> clock_tree_halt)
        else $error("deep sleep left without reset");
    deep_effect_a: assert property (clock_tree_halt |-> cpu_halt && io_freeze && !transfer_controller_en)
        else $error("deep sleep effects missing");
    pll_stop_a: assert property (pll_ref_stop |-> clock_tree_halt)
        else $error("pll reference stopped outside deep sleep");
    light_gate_a: assert property (cpu_clk_gate |-> cpu_halt)
        else $error("cpu clocks gated without halt");
    light_xfer_a: assert property (cpu_clk_gate && !clock_tree_halt |-> transfer_controller_en)
        else $error("transfers stopped in light sleep");
    service_pair_a: assert property (irq_service |-> resume && !clock_tree_halt)
        else $error("service without resume");
    resume_once_a: assert property (resume |=> !resume && !cpu_clk_gate)
        else $error("resume pulse wrong");
    spin_idle_a: assert property (emu_spin_idle |-> clock_tree_halt)
        else $error("spin idle outside deep sleep");
    frozen_a: assert property (io_freeze |=> $stable(pll_ref_stop) && io_freeze)
        else $error("frozen outputs moved");
endmodule // pdm_asserts
bind power_down_mode_control pdm_asserts chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .emu_attached(emu_attached),
    .cpu_clk_gate(cpu_clk_gate), .cpu_halt(cpu_halt), .irq_service(irq_service), .resume(resume),
    .transfer_controller_en(transfer_controller_en), .clock_tree_halt(clock_tree_halt),
    .pll_ref_stop(pll_ref_stop), .io_freeze(io_freeze), .emu_spin_idle(emu_spin_idle));

// ===== verification/power_down_mode_control_tb_top.sv
// Self-checking bench for the power-down mode controller.
// Assumes zero-wait APB answers and a lock wait shortened to 4 cycles.
`timescale 1ns/1ps
module power_down_mode_control_tb_top;
    import pdm_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, emu_attached = 0, emu_run_cmd = 0;
    logic test_rst_n = 0, cfg_hi = 0, cfg_lo = 0, pll_locked = 0, err, got_r, got_s;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [15:0] irq_pending = '0, ien;
    logic [5:0] code;
    logic [5:0] deep_q[$] = '{CODE_CLK_HALT, CODE_PLL_STOP};
    logic pready, pslverr, gate, halt, svc, resume, tc_en, ct_halt, ref_stop, freeze, spin, id_ok;
    logic [1:0] emul_mode;
    int n_errors = 0, n_compared = 0, cyc = 0, seed = 68638, k, n;
    always #2.5 pclk = ~pclk;
    power_down_mode_control #(.LOCK_WAIT(4)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq_pending(irq_pending), .emu_attached(emu_attached), .emu_run_cmd(emu_run_cmd),
        .test_rst_n(test_rst_n), .emul_config_pin_hi(cfg_hi), .emul_config_pin_lo(cfg_lo), .pll_locked(pll_locked),
        .cpu_clk_gate(gate), .cpu_halt(halt), .irq_service(svc), .resume(resume), .transfer_controller_en(tc_en),
        .clock_tree_halt(ct_halt), .pll_ref_stop(ref_stop), .io_freeze(freeze), .emu_spin_idle(spin),
        .idcode_variant_valid(id_ok), .emul_mode(emul_mode));
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_compared++;
        if (s !== e) begin
            $display("[ERR] %s expected %h seen %h", nm, e, s);
            n_errors++;
        end
    endtask
    // Answer signals are read at the falling edge before the rising edge that completes the transfer.
    // Reading them right after a rising edge would race the design's own updates at that edge.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(negedge pclk);
        while (pready !== 1'b1) @(negedge pclk);
        rd = prdata;
        err = pslverr;
        @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic watch(input int c);
        got_r = 0;
        got_s = 0;
        repeat (c) begin
            @(posedge pclk);
            got_r |= resume;
            got_s |= svc;
        end
    endtask
    task automatic wait_run();
        for (n = 0; n < 40; n++) begin
            apb(0, ADDR_STATUS, 0);
            if (rd === 32'h1) break;
        end
        chk("status_run", 32'h1, rd);
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            n_errors++;
            final_report();
        end
    end
    initial begin
        repeat (4) @(posedge pclk);
        chk("halt_in_reset", 1, halt);
        presetn <= 1'b1;
        pll_locked <= 1'b1;
        wait_run();
        apb(0, ADDR_CTRL, 0);
        chk("ctrl_reset", CTRL_RESET, rd);
        apb(0, 12'h010, 0);
        chk("unmapped_err", 1, err);
        cfg_hi <= 1'($random(seed));
        cfg_lo <= 1'b1;
        repeat (3) @(posedge pclk);
        test_rst_n <= 1'b1;
        repeat (6) @(posedge pclk);
        chk("emul_mode", {cfg_hi, cfg_lo}, emul_mode);
        chk("id_valid", 1, id_ok);
        $display("reset and config test done");
        // Case 0 wakes on any irq; case 1 enabled with both enables; case 2 enabled without global enable.
        for (k = 0; k < 3; k++) begin
            code = (k == 0) ? CODE_LIGHT_ANY : CODE_LIGHT_EN;
            ien = (k == 0) ? 16'h0000 : 16'h0006;
            apb(1, ADDR_IRQEN, {16'h0, ien});
            apb(1, ADDR_CTRL, {16'h0, code, 9'h0, k == 1});
            for (n = 0; n < 14 && gate !== 1'b1; n++) @(posedge pclk);
            chk("light_entry", 1, n < 12);
            chk("light_xfer", 1, tc_en);
            irq_pending <= 16'h0100;
            watch(6);
            chk("wake_early", k == 0, got_r);
            irq_pending <= (k == 0) ? 16'h0000 : 16'h0004;
            if (k != 0) watch(6);
            chk("svc", k == 1, got_s);
            irq_pending <= 16'h0000;
            apb(0, ADDR_STATUS, 0);
            chk("light_resumed", 32'h1, rd);
        end
        $display("light sleep test done");
        apb(1, ADDR_CTRL, {16'h0, 6'h05, 10'h0});
        repeat (14) @(posedge pclk);
        chk("reserved_code", 0, gate);
        emu_attached <= 1'b1;
        repeat (4) @(posedge pclk);
        apb(1, ADDR_CTRL, {16'h0, CODE_CLK_HALT, 10'h0});
        repeat (14) @(posedge pclk);
        chk("emu_mask", 0, halt);
        apb(1, ADDR_CTRL, 0);
        emu_attached <= 1'b0;
        $display("masking test done");
        foreach (deep_q[q]) begin
            apb(1, ADDR_CTRL, {16'h0, deep_q[q], 10'h0});
            for (n = 0; n < 14 && ct_halt !== 1'b1; n++) @(posedge pclk);
            chk("deep_entry", 1, ct_halt);
            chk("ref_stop", deep_q[q] == CODE_PLL_STOP, ref_stop);
            chk("freeze", 1, freeze);
            irq_pending <= $random(seed);
            emu_run_cmd <= 1'b1;
            apb(1, ADDR_CTRL, 0);
            watch(6);
            chk("deep_no_wake", 0, got_r);
            chk("spin_idle", 1, spin);
            presetn <= 1'b0;
            pll_locked <= 1'b0;
            emu_run_cmd <= 1'b0;
            irq_pending <= 16'h0000;
            repeat (2) @(posedge pclk);
            presetn <= 1'b1;
            repeat (10) @(posedge pclk);
            apb(0, ADDR_STATUS, 0);
            chk("wait_lock", 32'h10, rd);
            pll_locked <= 1'b1;
            wait_run();
        end
        $display("deep sleep test done");
        final_report();
    end
endmodule // power_down_mode_control_tb_top
